// ===== src/uipfc_ctrl.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Enabled CTS rise raises flow interrupt
// - Status read gives highest pending code
// - Line status 000110, timeout 001100
// - Rx ready 000100, tx 000010, modem 000000
// - Xoff 010000, flow 100000, idle 000001
// - Line errors interrupt; line read clears
// - Rx ready while fill at trigger
// - Timeout after four chars plus twelve bits
// - Tx ready on trigger/empty; status read clears
// - Modem bits interrupt; modem read clears
// - Xoff/special interrupt and their clears
// - Auto flow deassert interrupt; modem read clears
// - Wake-up interrupt cleared by status read
// - Status bit 0 low while a non-wake source pends
// - Status bits 4,5 need enhanced enable
// - Status bits 7:6 mirror queue enable
// - Queue enable bit gates other bits
// - Rx queue clear pulse, self clearing
// - Tx queue clear pulse, self clearing
// - Tx trigger select, enhanced only
// - Rx trigger select, reset level one
// - Enable bits 0-3 mask four sources
// - Enable bits 5,6 gate xoff, RTS
module uipfc_ctrl
    import uipfc_pkg::*;
#(
    parameter int CHAR_BITS = 10 // Bit times per character frame
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive side status
    input wire logic [7:0] rx_data,
    input wire logic [4:0] rx_count,
    input wire logic rx_char_stb,
    input wire logic bit_tick,
    input wire logic [7:0] line_condition_in,
    input wire logic [7:0] modem_condition_in,
    input wire logic xoff_det,
    input wire logic xon_det,
    input wire logic special_det,
    input wire logic wake_stb,
    // Transmit side status and flow pins
    input wire logic [4:0] tx_count,
    input wire logic cts_n_in,
    input wire logic rts_n_in,
    // Control outputs
    output logic irq,
    output logic fifo_enable,
    output logic rx_fifo_clear,
    output logic tx_fifo_clear,
    output logic [4:0] rx_trigger,
    output logic [4:0] tx_trigger,
    output logic auto_cts_en,
    output logic auto_rts_en,
    // Access strobes towards the datapath
    output logic tx_write_stb,
    output logic [7:0] tx_write_data,
    output logic rx_read_stb,
    output logic line_read_stb,
    output logic modem_read_stb
);

    localparam logic [TOUT_W-1:0] TOUT_LIMIT =
        TOUT_W'(TOUT_CHARS * CHAR_BITS + TOUT_BITS);

    typedef struct packed {
        logic [7:0] ien;        // Interrupt enables
        logic [7:0] enhanced_feature_reg;        // Enhanced feature bits
        logic fen;              // Queues enabled
        logic [1:0] rxt;        // Rx trigger select
        logic [1:0] txt;        // Tx trigger select
        logic rxclr;            // Rx clear pulse
        logic txclr;            // Tx clear pulse
        logic line;             // Line status pending
        logic modem;            // Modem status pending
        logic tout;             // Receive timeout pending
        logic tx;               // Tx ready pending
        logic xoff;             // Xoff seen
        logic spec;             // Special char seen
        logic flow;             // CTS/RTS change pending
        logic wake;             // Wake-up pending
        logic [TOUT_W-1:0] tcnt; // Timeout bit counter
        logic [4:0] txc_prev;   // Tx fill last cycle
        logic cts_prev;         // CTS pin last cycle
        logic rts_prev;         // RTS pin last cycle
        logic [5:0] snap;       // Code shown by status read
        logic [31:0] rdata;     // Read data
        logic txw;              // Holding write strobe
        logic [7:0] txd;        // Holding write data
        logic rxr;              // Holding read strobe
        logic lrd;              // Line read strobe
        logic mrd;              // Modem read strobe
    } uipfc_state_t;

    uipfc_state_t s_q;
    uipfc_state_t s_d;

    // Trigger level from a 2-bit select, shared by both queues
    function automatic logic [4:0] uipfc_level(input logic [1:0] sel);
        logic [4:0] l;
        l = LVL_0;
        case (sel)
            2'h1: l = LVL_1;
            2'h2: l = LVL_2;
            2'h3: l = LVL_3;
            default: l = LVL_0;
        endcase
        return l;
    endfunction : uipfc_level

    // Decoded register hits
    function automatic logic uipfc_hit(input logic [7:0] a,
                                       input logic [7:0] ofs);
        return a == ofs;
    endfunction : uipfc_hit

    // Qualified sources and current status code
    logic enh;
    logic rx_lvl;
    logic p_line, p_tout, p_rx, p_tx, p_modem, p_xoff, p_flow;
    logic pend;
    logic [5:0] code;
    logic setup, access, mapped;
    logic [4:0] rxlv, txlv;

    assign enh = s_q.enhanced_feature_reg[EFR_ENH];
    assign rxlv = uipfc_level(s_q.rxt);
    assign txlv = uipfc_level(s_q.txt);
    // Fill at trigger; without queues one char suffices
    assign rx_lvl = s_q.fen ? (rx_count >= rxlv) : (rx_count != 5'h00);
    assign p_line = s_q.line & s_q.ien[IEN_LINE];
    assign p_tout = s_q.tout & s_q.ien[IEN_RX];
    assign p_rx = rx_lvl & s_q.ien[IEN_RX];
    assign p_tx = s_q.tx & s_q.ien[IEN_TX];
    assign p_modem = s_q.modem & s_q.ien[IEN_MODEM];
    assign p_xoff = (s_q.xoff | s_q.spec) & s_q.ien[IEN_XOFF] & enh;
    assign p_flow = s_q.flow & enh;
    assign pend = p_line | p_tout | p_rx | p_tx | p_modem | p_xoff | p_flow;

    // Fixed priority encoder, level 1 highest
    always_comb begin
        if (p_line) begin
            code = CODE_LINE;
        end else if (p_tout) begin
            code = CODE_TOUT;
        end else if (p_rx) begin
            code = CODE_RX_DATA_READY_IRQ;
        end else if (p_tx) begin
            code = CODE_TX_READY_IRQ;
        end else if (p_modem) begin
            code = CODE_MODEM;
        end else if (p_xoff) begin
            code = CODE_XOFF;
        end else if (p_flow) begin
            code = CODE_FLOW;
        end else begin
            code = CODE_NONE;
        end
    end

    // Zero wait states: every access completes in its first cycle
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = uipfc_hit(paddr, OFS_HOLD) | uipfc_hit(paddr, OFS_IEN) |
                    uipfc_hit(paddr, OFS_ISR) | uipfc_hit(paddr, OFS_EFR) |
                    uipfc_hit(paddr, OFS_LSR) | uipfc_hit(paddr, OFS_MSR);

    // Next state of the whole block
    always_comb begin
        logic rd, wr, cts_rise, rts_rise;
        rd = access & ~pwrite;
        wr = access & pwrite;
        cts_rise = cts_n_in & ~s_q.cts_prev;
        rts_rise = rts_n_in & ~s_q.rts_prev;
        s_d = s_q;
        s_d.rxclr = 1'b0;
        s_d.txclr = 1'b0;
        s_d.txw = 1'b0;
        s_d.rxr = 1'b0;
        s_d.lrd = 1'b0;
        s_d.mrd = 1'b0;
        s_d.txc_prev = tx_count;
        s_d.cts_prev = cts_n_in;
        s_d.rts_prev = rts_n_in;

        // Read data captured in setup so it stands through access
        if (setup & ~pwrite) begin
            if (uipfc_hit(paddr, OFS_HOLD)) begin
                s_d.rdata = {24'h0, rx_data};
            end else if (uipfc_hit(paddr, OFS_IEN)) begin
                s_d.rdata = {24'h0, s_q.ien};
            end else if (uipfc_hit(paddr, OFS_ISR)) begin
                // Snapshot decides what the access phase clears
                s_d.rdata = {24'h0, {2{s_q.fen}}, code};
                s_d.snap = code;
                if (code == CODE_NONE && s_q.wake) begin
                    s_d.snap = CODE_NONE;
                end
            end else if (uipfc_hit(paddr, OFS_EFR)) begin
                s_d.rdata = {24'h0, s_q.enhanced_feature_reg};
            end else if (uipfc_hit(paddr, OFS_LSR)) begin
                s_d.rdata = {24'h0, line_condition_in};
            end else if (uipfc_hit(paddr, OFS_MSR)) begin
                s_d.rdata = {24'h0, modem_condition_in};
            end else begin
                s_d.rdata = 32'h0;
            end
        end

        // Clears caused by reads; sets below win in the same cycle
        if (rd && uipfc_hit(paddr, OFS_ISR)) begin
            if (s_q.snap == CODE_TX_READY_IRQ) begin
                s_d.tx = 1'b0;
            end
            if (s_q.snap == CODE_XOFF) begin
                s_d.xoff = 1'b0;
                s_d.spec = 1'b0;
            end
            s_d.wake = 1'b0;
        end
        if (rd && uipfc_hit(paddr, OFS_LSR)) begin
            s_d.line = 1'b0;
            s_d.lrd = 1'b1;
        end
        if (rd && uipfc_hit(paddr, OFS_MSR)) begin
            s_d.modem = 1'b0;
            s_d.flow = 1'b0;
            s_d.mrd = 1'b1;
        end
        if (rd && uipfc_hit(paddr, OFS_HOLD)) begin
            s_d.tout = 1'b0;
            s_d.rxr = 1'b1;
        end
        if (xon_det) begin
            s_d.xoff = 1'b0;
        end
        if (rx_char_stb) begin
            s_d.spec = 1'b0;
        end

        // Register writes
        if (wr) begin
            if (uipfc_hit(paddr, OFS_HOLD)) begin
                s_d.txw = 1'b1;
                s_d.txd = pwdata[7:0];
                s_d.tx = 1'b0;
            end else if (uipfc_hit(paddr, OFS_IEN)) begin
                // Upper enables only reachable in enhanced mode
                s_d.ien[3:0] = pwdata[3:0];
                if (enh) begin
                    s_d.ien[7:4] = pwdata[7:4];
                end
                // Enabling tx ready with an empty queue fires at once
                if (pwdata[IEN_TX] && !s_q.ien[IEN_TX] &&
                    tx_count == 5'h00) begin
                    s_d.tx = 1'b1;
                end
            end else if (uipfc_hit(paddr, OFS_ISR)) begin
                // Other bits only land when enable is written as 1
                s_d.fen = pwdata[QC_EN];
                if (pwdata[QC_EN]) begin
                    s_d.rxclr = pwdata[QC_RXCLR];
                    s_d.txclr = pwdata[QC_TXCLR];
                    s_d.rxt = pwdata[QC_RXT +: 2];
                    if (enh) begin
                        s_d.txt = pwdata[QC_TXT +: 2];
                    end
                end
            end else if (uipfc_hit(paddr, OFS_EFR)) begin
                s_d.enhanced_feature_reg = pwdata[7:0];
            end
        end

        // Timeout counter runs only while data waits in the queue
        if (rx_char_stb || (rd && uipfc_hit(paddr, OFS_HOLD)) ||
            rx_count == 5'h00 || !s_q.fen) begin
            s_d.tcnt = '0;
        end else if (bit_tick && s_q.tcnt != TOUT_LIMIT) begin
            s_d.tcnt = s_q.tcnt + TOUT_W'(1);
            if (s_q.tcnt + TOUT_W'(1) == TOUT_LIMIT) begin
                s_d.tout = 1'b1;
            end
        end

        // Event sets, placed last so they win over clears
        if (|line_condition_in[4:1]) begin
            s_d.line = 1'b1;
        end
        if (|modem_condition_in[3:0]) begin
            s_d.modem = 1'b1;
        end
        // Drop below trigger, or drain to empty
        if ((s_q.txc_prev >= txlv && tx_count < txlv) ||
            (s_q.txc_prev != 5'h00 && tx_count == 5'h00)) begin
            s_d.tx = 1'b1;
        end
        if (xoff_det) begin
            s_d.xoff = 1'b1;
        end
        if (special_det) begin
            s_d.spec = 1'b1;
        end
        if (enh && ((cts_rise && (s_q.ien[IEN_CTS] | s_q.enhanced_feature_reg[EFR_ACTS])) ||
                    (rts_rise && (s_q.ien[IEN_RTS] | s_q.enhanced_feature_reg[EFR_ARTS])))) begin
            s_d.flow = 1'b1;
        end
        if (wake_stb) begin
            s_d.wake = 1'b1;
        end
        // Clearing the rx queue also empties the timeout path
        if (s_q.rxclr) begin
            s_d.tcnt = '0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ien <= IEN_RST;
            s_q.enhanced_feature_reg <= EFR_RST;
            s_q.rxt <= TRIG_RST;
            s_q.txt <= TRIG_RST;
            s_q.snap <= CODE_NONE;
            s_q.cts_prev <= 1'b1;
            s_q.rts_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign irq = pend | s_q.wake;
    assign fifo_enable = s_q.fen;
    assign rx_fifo_clear = s_q.rxclr;
    assign tx_fifo_clear = s_q.txclr;
    assign rx_trigger = rxlv;
    assign tx_trigger = txlv;
    assign auto_cts_en = s_q.enhanced_feature_reg[EFR_ACTS];
    assign auto_rts_en = s_q.enhanced_feature_reg[EFR_ARTS];
    assign tx_write_stb = s_q.txw;
    assign tx_write_data = s_q.txd;
    assign rx_read_stb = s_q.rxr;
    assign line_read_stb = s_q.lrd;
    assign modem_read_stb = s_q.mrd;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_prio_line;
        p_line |-> code == CODE_LINE;
    endproperty
    a_prio_line: assert property (p_prio_line)
        else $error("line status not top priority");

    property p_isr_read;
        setup & ~pwrite & uipfc_hit(paddr, OFS_ISR)
            |=> prdata[5:0] == $past(code) &&
                prdata[7:6] == {2{$past(s_q.fen)}};
    endproperty
    a_isr_read: assert property (p_isr_read)
        else $error("status read returns wrong code");

    property p_idle_bit;
        (code[0] == 1'b1) == !pend;
    endproperty
    a_idle_bit: assert property (p_idle_bit)
        else $error("status bit 0 disagrees with pending");

    property p_irq;
        pend |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq low while pending");

    property p_qc_gate;
        access & pwrite & uipfc_hit(paddr, OFS_ISR) & ~pwdata[QC_EN]
            |=> !rx_fifo_clear && !tx_fifo_clear && $stable(rx_trigger);
    endproperty
    a_qc_gate: assert property (p_qc_gate)
        else $error("queue bits taken without enable");

    property p_rxclr_pulse;
        rx_fifo_clear |=> !rx_fifo_clear;
    endproperty
    a_rxclr_pulse: assert property (p_rxclr_pulse)
        else $error("rx clear did not self clear");

    property p_txclr_pulse;
        access & pwrite & uipfc_hit(paddr, OFS_ISR) & (pwdata[2:0] == 3'h5)
            |=> tx_fifo_clear ##1 !tx_fifo_clear;
    endproperty
    a_txclr_pulse: assert property (p_txclr_pulse)
        else $error("tx clear not a single pulse");

    property p_txt_enh;
        !enh |=> $stable(tx_trigger);
    endproperty
    a_txt_enh: assert property (p_txt_enh)
        else $error("tx trigger changed without enhanced mode");

    property p_rx_data_ready_irq;
        s_q.ien[IEN_RX] & s_q.fen & (rx_count >= rx_trigger) |-> pend;
    endproperty
    a_rx_data_ready_irq: assert property (p_rx_data_ready_irq)
        else $error("rx ready missing at trigger");

    property p_bits45;
        !enh |-> code != CODE_XOFF && code != CODE_FLOW;
    endproperty
    a_bits45: assert property (p_bits45)
        else $error("enhanced code shown while disabled");

    c_line_read: cover property (s_q.line ##[1:20] line_read_stb);
    c_timeout: cover property ($rose(s_q.tout));
    c_tx_clear: cover property (s_q.tx ##1 !s_q.tx);
    c_flow: cover property ($rose(s_q.flow));

endmodule : uipfc_ctrl

// ===== pkg/uipfc_pkg.sv
package uipfc_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] OFS_HOLD = 8'h00; // Rx read / tx write
    localparam logic [7:0] OFS_IEN = 8'h04; // Interrupt enables
    localparam logic [7:0] OFS_ISR = 8'h08; // Status read / queue write
    localparam logic [7:0] OFS_EFR = 8'h0c; // Enhanced features
    localparam logic [7:0] OFS_LSR = 8'h10; // Line condition read
    localparam logic [7:0] OFS_MSR = 8'h14; // Modem condition read
    // Interrupt status codes, bits 5..0
    localparam logic [5:0] CODE_LINE = 6'h06;
    localparam logic [5:0] CODE_TOUT = 6'h0c;
    localparam logic [5:0] CODE_RX_DATA_READY_IRQ = 6'h04;
    localparam logic [5:0] CODE_TX_READY_IRQ = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;
    // Field positions
    localparam int IEN_RX = 0;
    localparam int IEN_TX = 1;
    localparam int IEN_LINE = 2;
    localparam int IEN_MODEM = 3;
    localparam int IEN_XOFF = 5;
    localparam int IEN_RTS = 6;
    localparam int IEN_CTS = 7;
    localparam int EFR_ENH = 4;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int QC_EN = 0;
    localparam int QC_RXCLR = 1;
    localparam int QC_TXCLR = 2;
    localparam int QC_TXT = 4;
    localparam int QC_RXT = 6;
    // Reset values
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [1:0] TRIG_RST = 2'h0;
    // Trigger levels per 2-bit select
    localparam logic [4:0] LVL_0 = 5'h01;
    localparam logic [4:0] LVL_1 = 5'h04;
    localparam logic [4:0] LVL_2 = 5'h08;
    localparam logic [4:0] LVL_3 = 5'h0e;
    // Timeout: four characters plus this many bit times
    localparam int TOUT_CHARS = 4;
    localparam int TOUT_BITS = 12;
    localparam int TOUT_W = 8;
endpackage : uipfc_pkg

// ===== dv/uipfc_host.sv
`timescale 1ns/10ps
// Host processor model: a plain APB master
module uipfc_host
    import uipfc_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Slave answer
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // Bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q,
            output logic err, output logic tmo);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        // Legacy mode bit always left clear
        pwdata <= (wr && a == OFS_ISR) ? (d & ~32'h8) : d;
        @(posedge pclk);
        penable <= 1'b1;
        // Bounded wait so a dead slave cannot hang the run
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        tmo = (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : uipfc_host

// ===== dv/test_uart_irq_priority_fifo_ctrl.sv
`timescale 1ns/10ps
// Self-checking bench for the interrupt and queue control block
module test_uart_irq_priority_fifo_ctrl
    import uipfc_pkg::*;
;
    localparam int CB = 2; // Short frame keeps the timeout test quick
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rx_data = 8'h3c, lin = 8'h00, mdm = 8'h00;
    logic [4:0] rx_count = 5'h00, tx_count = 5'h00;
    // Event pulse lanes, one bit per strobe input
    localparam int TICK = 0, XOFF = 1, XON = 2, SPEC = 3, RXCH = 4, WAKE = 5;
    logic [5:0] ev = 6'h00;
    logic cts_n_in = 0, rts_n_in = 0;
    logic fen, rxclr, txclr, acts, arts, txs, rxs, lns, mds;
    logic [4:0] rxt, txt;
    logic [7:0] txd;
    int num_errors = 0;
    int tests_run = 0;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    uipfc_host host (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    uipfc_ctrl #(.CHAR_BITS(CB)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_data(rx_data), .rx_count(rx_count),
        .rx_char_stb(ev[RXCH]), .bit_tick(ev[TICK]),
        .line_condition_in(lin), .modem_condition_in(mdm),
        .xoff_det(ev[XOFF]), .xon_det(ev[XON]), .special_det(ev[SPEC]),
        .wake_stb(ev[WAKE]), .tx_count(tx_count), .cts_n_in(cts_n_in),
        .rts_n_in(rts_n_in), .irq(irq), .fifo_enable(fen),
        .rx_fifo_clear(rxclr), .tx_fifo_clear(txclr), .rx_trigger(rxt),
        .tx_trigger(txt), .auto_cts_en(acts), .auto_rts_en(arts),
        .tx_write_stb(txs), .tx_write_data(txd), .rx_read_stb(rxs),
        .line_read_stb(lns), .modem_read_stb(mds));

    // Verdict and stop
    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Compare seen against expected
    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Bus access; a hung bus ends the run
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [31:0] q, output logic e);
        logic t;
        host.xfer(w, a, {24'h0, d}, q, e, t);
        if (t !== 1'b0) begin
            num_errors++;
            end_of_test();
        end
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        acc(1'b1, a, d, q, e);
    endtask : wr

    // Read with a check of the returned word
    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        repeat (2) @(posedge pclk);
        acc(1'b0, a, 8'h00, q, e);
        check(nm, q, exp);
    endtask : rdc

    // Expected status word from queue state and code
    function automatic logic [31:0] sw(input logic f, input logic [5:0] c);
        return {24'h0, f, f, c};
    endfunction : sw

    // One-cycle event pulse, settled afterwards
    task automatic pulse(input int k);
        @(posedge pclk);
        ev <= 6'h01 << k;
        @(posedge pclk);
        ev <= 6'h00;
        repeat (2) @(posedge pclk);
        #1;
    endtask : pulse

    // Reset state and queue control write
    task automatic t_queue();
        check("irq", 32'(irq), 32'h0);
        rdc("status", OFS_ISR, sw(0, CODE_NONE));
        check("rxtrig", 32'(rxt), 32'(LVL_0));
        wr(OFS_ISR, 8'hf7);
        #1;
        check("rxclr", 32'(rxclr), 32'h1);
        check("txclr", 32'(txclr), 32'h1);
        check("txtrig", 32'(txt), 32'(LVL_0));
        @(posedge pclk);
        #1;
        check("clrs", 32'({rxclr, txclr}), 32'h0);
        check("rxtrig", 32'(rxt), 32'(LVL_3));
        rdc("status", OFS_ISR, sw(1, CODE_NONE));
        wr(OFS_ISR, 8'h86);
        #1;
        check("rxclr", 32'(rxclr), 32'h0);
        check("fen", 32'(fen), 32'h0);
        check("rxtrig", 32'(rxt), 32'(LVL_3));
    endtask : t_queue

    // Priority walk through four sources
    task automatic t_prio();
        @(posedge pclk);
        rx_count <= 5'h01;
        lin <= 8'h02;
        mdm <= 8'h01;
        @(posedge pclk);
        lin <= 8'h00;
        mdm <= 8'h00;
        repeat (2) @(posedge pclk);
        #1;
        check("irq", 32'(irq), 32'h0);
        wr(OFS_IEN, 8'h0f);
        rdc("status", OFS_ISR, sw(0, CODE_LINE));
        check("irq", 32'(irq), 32'h1);
        rdc("line", OFS_LSR, 32'h0);
        #1;
        check("lstb", 32'(lns), 32'h1);
        rdc("status", OFS_ISR, sw(0, CODE_RX_DATA_READY_IRQ));
        rx_count <= 5'h00;
        rdc("status", OFS_ISR, sw(0, CODE_TX_READY_IRQ));
        rdc("status", OFS_ISR, sw(0, CODE_MODEM));
        rdc("modem", OFS_MSR, 32'h0);
        #1;
        check("mstb", 32'(mds), 32'h1);
        rdc("status", OFS_ISR, sw(0, CODE_NONE));
        check("irq", 32'(irq), 32'h0);
    endtask : t_prio

    // Receive timeout on bit ticks
    task automatic t_tout();
        wr(OFS_IEN, 8'h01);
        wr(OFS_ISR, 8'h41);
        rx_count <= 5'h01;
        repeat (TOUT_CHARS * CB + TOUT_BITS - 1) pulse(TICK);
        check("irq", 32'(irq), 32'h0);
        repeat (2) pulse(TICK);
        rdc("status", OFS_ISR, sw(1, CODE_TOUT));
        rdc("hold", OFS_HOLD, 32'h3c);
        #1;
        check("rstb", 32'(rxs), 32'h1);
        rdc("status", OFS_ISR, sw(1, CODE_NONE));
        rx_count <= 5'h00;
    endtask : t_tout

    // Enhanced sources and wake-up
    task automatic t_enh();
        wr(OFS_IEN, 8'he0);
        rdc("ien", OFS_IEN, 32'h0);
        wr(OFS_EFR, 8'h10);
        wr(OFS_IEN, 8'he0);
        pulse(XOFF);
        rdc("status", OFS_ISR, sw(1, CODE_XOFF));
        rdc("status", OFS_ISR, sw(1, CODE_NONE));
        pulse(XOFF);
        pulse(XON);
        check("irq", 32'(irq), 32'h0);
        pulse(SPEC);
        check("irq", 32'(irq), 32'h1);
        pulse(RXCH);
        check("irq", 32'(irq), 32'h0);
        cts_n_in <= 1'b1;
        rdc("status", OFS_ISR, sw(1, CODE_FLOW));
        rdc("modem", OFS_MSR, 32'h0);
        rdc("status", OFS_ISR, sw(1, CODE_NONE));
        rts_n_in <= 1'b1;
        rdc("status", OFS_ISR, sw(1, CODE_FLOW));
        rdc("modem", OFS_MSR, 32'h0);
        pulse(WAKE);
        check("irq", 32'(irq), 32'h1);
        rdc("status", OFS_ISR, sw(1, CODE_NONE));
        #1;
        check("irq", 32'(irq), 32'h0);
    endtask : t_enh

    // Transmit trigger, holding write, unmapped place
    task automatic t_tx();
        logic [31:0] q;
        logic e;
        wr(OFS_ISR, 8'h35);
        #1;
        check("txtrig", 32'(txt), 32'(LVL_3));
        check("txclr", 32'(txclr), 32'h1);
        tx_count <= 5'h0e;
        wr(OFS_IEN, 8'h02);
        tx_count <= 5'h0d;
        repeat (3) @(posedge pclk);
        #1;
        check("irq", 32'(irq), 32'h1);
        wr(OFS_HOLD, 8'h5a);
        #1;
        check("txstb", 32'({txs, txd}), 32'h15a);
        repeat (2) @(posedge pclk);
        #1;
        check("irq", 32'(irq), 32'h0);
        // Drain from below trigger straight to empty
        tx_count <= 5'h00;
        repeat (3) @(posedge pclk);
        #1;
        check("irq", 32'(irq), 32'h1);
        acc(1'b0, 8'h1c, 8'h00, q, e);
        check("unmapped", q, 32'h0);
        check("slverr", 32'(e), 32'h1);
        wr(OFS_EFR, 8'hd0);
        #1;
        check("auto", 32'({acts, arts}), 32'h3);
    endtask : t_tx

    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_queue();
        t_prio();
        t_tout();
        t_enh();
        t_tx();
        end_of_test();
    end
endmodule : test_uart_irq_priority_fifo_ctrl
